// ===== verilog/drs_regs.svh
// Register offsets, reset values, codes and timing constants.
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH

`define DRS_OFS_TERM0    8'h00
`define DRS_OFS_TERM1    8'h04
`define DRS_OFS_TERM2    8'h08
`define DRS_OFS_SENS     8'h0C
`define DRS_OFS_FWD      8'h10
`define DRS_OFS_REV      8'h14
`define DRS_OFS_START    8'h18
`define DRS_OFS_OC_LVL   8'h1C
`define DRS_OFS_OC_DLY   8'h20
`define DRS_OFS_ZC_LVL   8'h24
`define DRS_OFS_ZC_TIME  8'h28
`define DRS_OFS_STATUS   8'h2C
`define DRS_OFS_TERMS    8'h30

`define DRS_RST_TERM0    8'h00
`define DRS_RST_TERM1    8'h04
`define DRS_RST_TERM2    8'h63
`define DRS_RST_SENS     7'h0A
`define DRS_MAX_SENS     7'h64
`define DRS_RST_FWD      16'h0258
`define DRS_MAX_FREQ     16'h9C40
`define DRS_REV_SAME     16'h270F
`define DRS_RST_START    16'h0032
`define DRS_RST_OC_LVL   16'h05DC
`define DRS_MAX_LVL      16'h07D0
`define DRS_RST_OC_DLY   16'h0000
`define DRS_MAX_OC_DLY   16'h2710
`define DRS_RST_ZC_LVL   16'h0032
`define DRS_RST_ZC_TIME  16'h01F4
`define DRS_MAX_ZC_TIME  16'h03E8

`define DRS_FN_RUN       7'h00
`define DRS_FN_SU        7'h01
`define DRS_FN_FU        7'h04
`define DRS_FN_RY        7'h0B
`define DRS_FN_OC        7'h0C
`define DRS_FN_ZC        7'h0D
`define DRS_FN_IFLT      7'h5B
`define DRS_FN_FLT       7'h63
`define DRS_NEG_BASE     8'h64
`define DRS_CODE_MAX     8'hC7

`define DRS_PCT_FULL     23'h000064
`define DRS_CLK_PERIOD_NS 32'h00000014
`define DRS_MS_NS        32'h000F4240
`define DRS_ZC_HOLD_MS   16'h0064

`endif

// ===== verilog/drs_pkg.sv
// Types shared by the drive status output block.
package drs_pkg;

  typedef struct packed {
    logic zero_current_indication;
    logic overcurrent_indication;
    logic frequency_threshold;
    logic up_to_frequency;
    logic internal_fault_indication;
    logic fault_indication;
    logic drive_ready;
    logic running;
  } drs_ind_t;

  typedef struct packed {
    logic able_to_operate;
    logic operating;
    logic reverse;
    logic dc_brake;
    logic coasting;
    logic power_fail;
    logic restarting;
    logic fault_trip;
    logic output_shutoff_input;
  } drs_state_t;

  typedef struct packed {
    logic brake_transistor;
    logic output_earth_fault;
    logic output_phase_loss;
    logic param_storage;
    logic internal_board;
    logic processor;
    logic inrush_limiter;
  } drs_int_fault_t;

endpackage : drs_pkg

// ===== verilog/drs_status_out.sv
// Drive status indications and output terminal routing.
//
// Operation
// - One function may drive several terminals at once.
// - Codes 0..99 conduct while active; codes 100..199 invert.
// - Ready is on whenever the drive can operate, also while running, but off while coasting on power failure.
// - Running is on at or above starting frequency, off stopped or braking.
// - Ready is code 11 or 111; running is code 0 or 100.
// - Trip or shutoff clears both; restart sets both; coasting clears run.
// - After reset terminal 0 carries positive running.
// - Fault follows trips, default on relay, code 99 or 199.
// - Internal fault from seven circuit faults, code 91 or 191.
// - Earth fault shown as acceleration overcurrent still sets internal fault.
// - Up-to-frequency inside a percent band of set frequency, default 10.
// - Up-to-frequency is code 1 or 101.
// - Threshold on at or above forward detect frequency, default 6 Hz.
// - Reverse uses its own detect frequency; 9999 means use forward.
// - After reset terminal 1 carries threshold; code 4 or 104.
// - Up-to-frequency and threshold are off during DC braking.
// - Frequencies compare on output frequency before slip compensation.
// - Overcurrent level in percent of rated, 0..200, default 150.
// - Overcurrent after level exceeded for the delay, 0..10 s.
// - Zero current after below level for the time, default 0.5 s.
// - Zero current indication holds about 100 ms once on.
// - Current detection only while the drive is operating.
// - Overcurrent is code 12 or 112.
// - Zero current is code 13 or 113.
`timescale 1ns/10ps
`include "drs_regs.svh"

module drs_status_out #(
  parameter int unsigned MS_TICK_CYCLES = `DRS_MS_NS / `DRS_CLK_PERIOD_NS
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  clk_en_in,
  input  wire logic [7:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rdata_out,
  input  wire drs_pkg::drs_state_t     state_in,
  input  wire drs_pkg::drs_int_fault_t int_fault_in,
  input  wire logic [15:0]           out_freq_in,
  input  wire logic [15:0]           set_freq_in,
  input  wire logic [15:0]           out_current_in,
  output drs_pkg::drs_ind_t          ind_out,
  output logic      [2:0]            terminal_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]         code_q [3];
  logic [6:0]         sens_q;
  logic [15:0]        fwd_q;
  logic [15:0]        rev_q;
  logic [15:0]        start_q;
  logic [15:0]        oc_lvl_q;
  logic [15:0]        oc_dly_q;
  logic [15:0]        zc_lvl_q;
  logic [15:0]        zc_time_q;
  logic [31:0]        rdata_q;
  drs_pkg::drs_ind_t  ind_q;
  logic [2:0]         term_q;
  logic [15:0]        tick_cnt_q;
  logic               ms_tick;
  logic [15:0]        oc_ms_q;
  logic [15:0]        zc_ms_q;
  logic [15:0]        zc_hold_q;
  logic               oc_ind_q;
  logic               zc_ind_q;

  // ****************************************************************
  // Write clamping helpers
  // ****************************************************************
  function automatic logic [15:0] clamp16(input logic [31:0] v,
                                          input logic [15:0] mx);
    if (v > {16'h0000, mx}) begin
      clamp16 = mx;
    end else begin
      clamp16 = v[15:0];
    end
  endfunction : clamp16

  function automatic logic [15:0] rev_val(input logic [31:0] v);
    if (v[15:0] == `DRS_REV_SAME && v[31:16] == 16'h0000) begin
      rev_val = `DRS_REV_SAME;
    end else begin
      rev_val = clamp16(v, `DRS_MAX_FREQ);
    end
  endfunction : rev_val

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      code_q[0] <= `DRS_RST_TERM0;
      code_q[1] <= `DRS_RST_TERM1;
      code_q[2] <= `DRS_RST_TERM2;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == `DRS_OFS_TERM0) begin
        code_q[0] <= wdata_in[7:0];
      end
      if (addr_in == `DRS_OFS_TERM1) begin
        code_q[1] <= wdata_in[7:0];
      end
      if (addr_in == `DRS_OFS_TERM2) begin
        code_q[2] <= wdata_in[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      sens_q <= `DRS_RST_SENS;
      fwd_q  <= `DRS_RST_FWD;
      rev_q  <= `DRS_REV_SAME;
      start_q <= `DRS_RST_START;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == `DRS_OFS_SENS) begin
        sens_q <= 7'(clamp16(wdata_in, {9'h000, `DRS_MAX_SENS}));
      end
      if (addr_in == `DRS_OFS_FWD) begin
        fwd_q <= clamp16(wdata_in, `DRS_MAX_FREQ);
      end
      if (addr_in == `DRS_OFS_REV) begin
        rev_q <= rev_val(wdata_in);
      end
      if (addr_in == `DRS_OFS_START) begin
        start_q <= clamp16(wdata_in, `DRS_MAX_FREQ);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      oc_lvl_q  <= `DRS_RST_OC_LVL;
      oc_dly_q  <= `DRS_RST_OC_DLY;
      zc_lvl_q  <= `DRS_RST_ZC_LVL;
      zc_time_q <= `DRS_RST_ZC_TIME;
    end else if (clk_en_in && wr_in) begin
      if (addr_in == `DRS_OFS_OC_LVL) begin
        oc_lvl_q <= clamp16(wdata_in, `DRS_MAX_LVL);
      end
      if (addr_in == `DRS_OFS_OC_DLY) begin
        oc_dly_q <= clamp16(wdata_in, `DRS_MAX_OC_DLY);
      end
      if (addr_in == `DRS_OFS_ZC_LVL) begin
        zc_lvl_q <= clamp16(wdata_in, `DRS_MAX_LVL);
      end
      if (addr_in == `DRS_OFS_ZC_TIME) begin
        zc_time_q <= clamp16(wdata_in, `DRS_MAX_ZC_TIME);
      end
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= 32'h00000000;
    end else if (clk_en_in) begin
      rdata_q <= 32'h00000000;
      if (rd_in) begin
        unique case (addr_in)
          `DRS_OFS_TERM0:   rdata_q[7:0]  <= code_q[0];
          `DRS_OFS_TERM1:   rdata_q[7:0]  <= code_q[1];
          `DRS_OFS_TERM2:   rdata_q[7:0]  <= code_q[2];
          `DRS_OFS_SENS:    rdata_q[6:0]  <= sens_q;
          `DRS_OFS_FWD:     rdata_q[15:0] <= fwd_q;
          `DRS_OFS_REV:     rdata_q[15:0] <= rev_q;
          `DRS_OFS_START:   rdata_q[15:0] <= start_q;
          `DRS_OFS_OC_LVL:  rdata_q[15:0] <= oc_lvl_q;
          `DRS_OFS_OC_DLY:  rdata_q[15:0] <= oc_dly_q;
          `DRS_OFS_ZC_LVL:  rdata_q[15:0] <= zc_lvl_q;
          `DRS_OFS_ZC_TIME: rdata_q[15:0] <= zc_time_q;
          `DRS_OFS_STATUS:  rdata_q[7:0]  <= ind_q;
          `DRS_OFS_TERMS:   rdata_q[2:0]  <= term_q;
          default:          rdata_q       <= 32'h00000000;
        endcase
      end
    end
  end

  assign rdata_out = rdata_q;

  // ****************************************************************
  // Drive state indications
  // ****************************************************************
  logic               at_start_freq;
  logic               blocked;
  logic               ready_d;
  logic               run_d;
  logic               int_fault_d;

  assign at_start_freq = out_freq_in >= start_q;
  assign blocked = state_in.fault_trip ||
                   state_in.output_shutoff_input;

  always_comb begin
    ready_d = state_in.able_to_operate;
    if (state_in.coasting && state_in.power_fail) begin
      ready_d = 1'b0;
    end
    if (state_in.restarting) begin
      ready_d = 1'b1;
    end
    if (blocked) begin
      ready_d = 1'b0;
    end
  end

  always_comb begin
    run_d = at_start_freq && !state_in.coasting;
    if (state_in.restarting) begin
      run_d = 1'b1;
    end
    if (blocked || state_in.dc_brake) begin
      run_d = 1'b0;
    end
  end

  // An earth fault may surface as an acceleration overcurrent trip; the
  // earth fault flag itself is what raises the indication.
  assign int_fault_d = int_fault_in.brake_transistor ||
                       int_fault_in.output_earth_fault ||
                       int_fault_in.output_phase_loss ||
                       int_fault_in.param_storage ||
                       int_fault_in.internal_board ||
                       int_fault_in.processor ||
                       int_fault_in.inrush_limiter;

  // ****************************************************************
  // Frequency indications
  // ****************************************************************
  logic [22:0]        band_prod;
  logic [22:0]        band;
  logic [15:0]        freq_diff;
  logic [15:0]        detect_freq;
  logic               su_d;
  logic               fu_d;

  // Output frequency arrives before slip compensation is added.
  assign band_prod = set_freq_in * {9'h000, sens_q};
  assign band = band_prod / `DRS_PCT_FULL;
  assign freq_diff = (out_freq_in >= set_freq_in) ?
                     (out_freq_in - set_freq_in) :
                     (set_freq_in - out_freq_in);
  assign detect_freq = (state_in.reverse && rev_q != `DRS_REV_SAME) ?
                       rev_q : fwd_q;
  assign su_d = ({7'h00, freq_diff} <= band) &&
                !state_in.dc_brake;
  assign fu_d = (out_freq_in >= detect_freq) &&
                !state_in.dc_brake;

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      tick_cnt_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (ms_tick) begin
        tick_cnt_q <= 16'h0000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
    end
  end

  assign ms_tick = tick_cnt_q == 16'(MS_TICK_CYCLES - 1);

  // ****************************************************************
  // Overcurrent detection
  // ****************************************************************
  logic               oc_qual;

  assign oc_qual = state_in.operating &&
                   (out_current_in > oc_lvl_q);

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      oc_ms_q  <= 16'h0000;
      oc_ind_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!oc_qual) begin
        oc_ms_q  <= 16'h0000;
        oc_ind_q <= 1'b0;
      end else if (oc_ms_q >= oc_dly_q) begin
        oc_ind_q <= 1'b1;
      end else if (ms_tick) begin
        oc_ms_q <= oc_ms_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Zero current detection
  // ****************************************************************
  logic               zc_qual;
  logic               zc_hold_done;

  // A zero level of zero disables the detection.
  assign zc_qual = state_in.operating &&
                   (zc_lvl_q != 16'h0000) &&
                   (out_current_in < zc_lvl_q);
  assign zc_hold_done = zc_hold_q >= `DRS_ZC_HOLD_MS;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      zc_ms_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (!zc_qual) begin
        zc_ms_q <= 16'h0000;
      end else if (ms_tick && zc_ms_q < zc_time_q) begin
        zc_ms_q <= zc_ms_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      zc_ind_q  <= 1'b0;
      zc_hold_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (!zc_ind_q) begin
        zc_hold_q <= 16'h0000;
        if (zc_qual && zc_ms_q >= zc_time_q) begin
          zc_ind_q <= 1'b1;
        end
      end else begin
        if (ms_tick && !zc_hold_done) begin
          zc_hold_q <= zc_hold_q + 16'h0001;
        end
        if (zc_hold_done && !(zc_qual && zc_ms_q >= zc_time_q)) begin
          zc_ind_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Indication register
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ind_q <= '0;
    end else if (clk_en_in) begin
      ind_q.running                   <= run_d;
      ind_q.drive_ready               <= ready_d;
      ind_q.fault_indication          <= state_in.fault_trip;
      ind_q.internal_fault_indication <= int_fault_d;
      ind_q.up_to_frequency           <= su_d;
      ind_q.frequency_threshold       <= fu_d;
      ind_q.overcurrent_indication    <= oc_ind_q;
      ind_q.zero_current_indication   <= zc_ind_q;
    end
  end

  assign ind_out = ind_q;

  // ****************************************************************
  // Terminal routing
  // ****************************************************************
  function automatic logic pick(input logic [6:0] fn,
                                input drs_pkg::drs_ind_t ind);
    case (fn)
      `DRS_FN_RUN:  pick = ind.running;
      `DRS_FN_SU:   pick = ind.up_to_frequency;
      `DRS_FN_FU:   pick = ind.frequency_threshold;
      `DRS_FN_RY:   pick = ind.drive_ready;
      `DRS_FN_OC:   pick = ind.overcurrent_indication;
      `DRS_FN_ZC:   pick = ind.zero_current_indication;
      `DRS_FN_IFLT: pick = ind.internal_fault_indication;
      `DRS_FN_FLT:  pick = ind.fault_indication;
      default:      pick = 1'b0;
    endcase
  endfunction : pick

  // Unassigned codes below 100 leave the terminal off, inverted ones (100..199) turn it on; codes above 199 are off.
  function automatic logic route(input logic [7:0] code,
                                 input drs_pkg::drs_ind_t ind);
    logic [7:0] neg;
    neg = code - `DRS_NEG_BASE;
    if (code < `DRS_NEG_BASE) begin
      route = pick(code[6:0], ind);
    end else if (code <= `DRS_CODE_MAX) begin
      route = !pick(neg[6:0], ind);
    end else begin
      route = 1'b0;
    end
  endfunction : route

  // Every terminal decodes its own code, so codes may repeat.
  for (genvar g = 0; g < 3; g++) begin : g_term
    always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
        term_q[g] <= 1'b0;
      end else if (clk_en_in) begin
        term_q[g] <= route(code_q[g], ind_q);
      end
    end
  end

  assign terminal_out = term_q;

endmodule : drs_status_out

// ===== testbench/drs_status_out_sva.sv
// Concurrent checks on the drive status output block ports.
`timescale 1ns/10ps
module drs_status_out_sva (
  input wire logic                    ref_clk_in,
  input wire logic                    reset_n_in,
  input wire logic                    clk_en_in,
  input wire logic [7:0]              addr_in,
  input wire logic                    rd_in,
  input wire logic [31:0]             rdata_out,
  input wire drs_pkg::drs_state_t     state_in,
  input wire drs_pkg::drs_int_fault_t int_fault_in,
  input wire drs_pkg::drs_ind_t       ind_out
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in || !clk_en_in);
  chk_fault_follow: assert property ($past(reset_n_in) |->
    ind_out.fault_indication == $past(state_in.fault_trip))
    else $error("fault indication does not follow trip");
  chk_ifault_or: assert property ($past(reset_n_in) |->
    ind_out.internal_fault_indication == $past(|int_fault_in))
    else $error("internal fault indication wrong");
  chk_trip_clears: assert property (
    $past(reset_n_in) && $past(state_in.fault_trip |
    state_in.output_shutoff_input) |-> !ind_out.drive_ready && !ind_out.running)
    else $error("ready or running on during trip");
  chk_restart_sets: assert property ($past(reset_n_in) &&
    $past(state_in.restarting && !state_in.fault_trip &&
    !state_in.output_shutoff_input && !state_in.dc_brake)
    |-> ind_out.drive_ready && ind_out.running)
    else $error("restart did not set ready and running");
  chk_brake_off: assert property ($past(state_in.dc_brake)
    |-> !ind_out.up_to_frequency && !ind_out.frequency_threshold &&
    !ind_out.running) else $error("indication on during braking");
  chk_read_idle: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  chk_status_read: assert property (rd_in && addr_in == 8'h2C |=>
    rdata_out == {24'h0, $past(ind_out)})
    else $error("status read mismatch");
  chk_oc_idle: assert property (!state_in.operating [*3] |->
    !ind_out.overcurrent_indication)
    else $error("overcurrent while not operating");
  chk_oc_rise: assert property ($rose(ind_out.overcurrent_indication)
    |-> $past(state_in.operating, 2))
    else $error("overcurrent rose without operation");
  cov_trip: cover property ($rose(ind_out.fault_indication));
  cov_oc: cover property ($rose(ind_out.overcurrent_indication));
  cov_zc: cover property ($fell(ind_out.zero_current_indication));
endmodule : drs_status_out_sva

bind drs_status_out drs_status_out_sva i_sva (.ref_clk_in, .reset_n_in,
  .clk_en_in, .addr_in, .rd_in, .rdata_out, .state_in, .int_fault_in,
  .ind_out);

// ===== testbench/drs_term_reader.sv
// Relay and brake equipment that latches the output terminals.
`timescale 1ns/10ps
module drs_term_reader (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [2:0] terminal_in,
  output logic      [2:0] relay_q_out
);
  // The coils pick up one clock after a terminal conducts.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      relay_q_out <= 3'h0;
    end else begin
      relay_q_out <= terminal_in;
    end
  end
endmodule : drs_term_reader

// ===== testbench/drs_status_out_tb.sv
// Self-checking bench of the drive status output block.
`timescale 1ns/10ps
`include "drs_regs.svh"
module drs_status_out_tb;
  logic                    ref_clk_in, reset_n_in, clk_en_in, wr_in, rd_in;
  logic [7:0]              addr_in;
  logic [31:0]             wdata_in, rdata_out, rv, seed, r;
  drs_pkg::drs_state_t     st;
  drs_pkg::drs_int_fault_t ifl;
  drs_pkg::drs_ind_t       ind;
  logic [15:0]             fo, fs, cur, rev;
  logic [2:0]              term, relay;
  logic [7:0]              code;
  int                      num_errors, total_checks, n, i, p;
  logic [7:0]  ofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                            8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [31:0] rst [11] = '{`DRS_RST_TERM0, `DRS_RST_TERM1, `DRS_RST_TERM2,
    `DRS_RST_SENS, `DRS_RST_FWD, `DRS_REV_SAME, `DRS_RST_START,
    `DRS_RST_OC_LVL, `DRS_RST_OC_DLY, `DRS_RST_ZC_LVL, `DRS_RST_ZC_TIME};
  logic [7:0]  cd [8] = '{8'h00, 8'h0B, 8'h63, 8'h5B,
                          8'h01, 8'h04, 8'h0C, 8'h0D};

  drs_status_out #(.MS_TICK_CYCLES(10)) i_dut (.ref_clk_in, .reset_n_in,
    .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .state_in(st), .int_fault_in(ifl), .out_freq_in(fo), .set_freq_in(fs),
    .out_current_in(cur), .ind_out(ind), .terminal_out(term));
  drs_term_reader i_relay (.ref_clk_in, .reset_n_in, .terminal_in(term),
    .relay_q_out(relay));

  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected low six indication bits from the drive state.
  function automatic logic [5:0] exp_ind(drs_pkg::drs_state_t s);
    logic k, run, rdy;
    logic [31:0] d, b, det;
    k = s.fault_trip | s.output_shutoff_input;
    run = ((fo >= `DRS_RST_START) & !s.coasting | s.restarting) & !k;
    rdy = (s.able_to_operate & !(s.coasting & s.power_fail)
          | s.restarting) & !k;
    d = (fo > fs) ? 32'(fo - fs) : 32'(fs - fo);
    b = 32'(fs) * 32'h0000000A / 32'h00000064;
    det = (s.reverse && rev != `DRS_REV_SAME) ? 32'(rev) : `DRS_RST_FWD;
    return {32'(fo) >= det && !s.dc_brake, d <= b && !s.dc_brake,
            |ifl, s.fault_trip, rdy, run && !s.dc_brake};
  endfunction : exp_ind

  task automatic chk(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask : rd

  // Waits up to lim cycles for a bit of the indications to reach v.
  task automatic wait_ind(input int b, input logic v, input int lim);
    n = 0;
    while (ind[b] !== v && n < lim) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    if (ind[b] !== v) begin
      num_errors++;
      $display("[FAIL] wait indication %0d expected %b seen %b",
               b, v, ind[b]);
      stop_test();
    end
  endtask : wait_ind
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {wr_in, rd_in, addr_in, wdata_in, st, ifl, fo, fs, cur} = '0;
    {num_errors, total_checks} = '0;
    seed = 32'h434F2119;
    rev = `DRS_REV_SAME;
    clk_en_in = 1'b1;
    reset_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 11; i++) begin
      rd(ofs[i]);
      chk("reset value", rv, rst[i]);
    end
    rd(8'h40);
    chk("unmapped read", rv, 32'h0);
    wr(`DRS_OFS_SENS, 32'h000000C8);
    rd(`DRS_OFS_SENS);
    chk("sensitivity clamp", rv, `DRS_MAX_SENS);
    wr(`DRS_OFS_SENS, 32'h0000000A);
    $display("registers done");
    for (p = 0; p < 400; p++) begin
      if (p == 200) begin
        rev = 16'h03E8;
        wr(`DRS_OFS_REV, 32'h000003E8);
      end
      r = rnd();
      @(posedge ref_clk_in);
      st <= r[8:0];
      ifl <= r[15:9] & r[22:16] & r[29:23];
      fs <= {2'h0, r[31:18]};
      fo <= {2'h0, r[31:18]} + {{6{r[9]}}, r[9:0]};
      @(posedge ref_clk_in);
      #1 chk("indications", ind[5:0], exp_ind(st));
    end
    $display("indications done");
    for (i = 0; i < 16; i++) begin
      code = cd[i % 8] + ((i >= 8) ? 8'h64 : 8'h00);
      wr(`DRS_OFS_TERM0, 32'(code));
      wr(`DRS_OFS_TERM1, 32'(code));
      repeat (3) @(posedge ref_clk_in);
      #1 chk("terminal", term[0], ind[i % 8] ^ (i >= 8));
      chk("shared code", term[1], term[0]);
      chk("relay", relay, term);
    end
    rd(`DRS_OFS_STATUS);
    chk("status read", rv, {24'h000000, ind});
    rd(`DRS_OFS_TERMS);
    chk("terminal read", rv, {29'h0, term});
    wr(`DRS_OFS_TERM0, 32'h000000C8);
    repeat (3) @(posedge ref_clk_in);
    #1 chk("unused code", term[0], 1'b0);
    wr(`DRS_OFS_TERM0, 32'h0);
    wr(`DRS_OFS_TERM1, 32'h4);
    $display("terminals done");
    wr(`DRS_OFS_OC_DLY, 32'h3);
    @(posedge ref_clk_in);
    st <= 9'h180;
    cur <= 16'h0640;
    repeat (15) @(posedge ref_clk_in);
    cur <= 16'h0000;
    @(posedge ref_clk_in);
    cur <= 16'h0640;
    repeat (15) @(posedge ref_clk_in);
    #1 chk("oc early", ind.overcurrent_indication, 1'b0);
    wait_ind(6, 1'b1, 60);
    chk("oc set", ind.overcurrent_indication, 1'b1);
    @(posedge ref_clk_in);
    st <= 9'h100;
    repeat (3) @(posedge ref_clk_in);
    #1 chk("oc idle", ind.overcurrent_indication, 1'b0);
    wr(`DRS_OFS_ZC_TIME, 32'h5);
    @(posedge ref_clk_in);
    st <= 9'h180;
    cur <= 16'h000A;
    wait_ind(7, 1'b1, 100);
    chk("zc set", ind.zero_current_indication, 1'b1);
    @(posedge ref_clk_in);
    cur <= 16'h03E8;
    repeat (900) @(posedge ref_clk_in);
    #1 chk("zc hold", ind.zero_current_indication, 1'b1);
    wait_ind(7, 1'b0, 300);
    chk("zc clear", ind.zero_current_indication, 1'b0);
    $display("current done");
    @(posedge ref_clk_in);
    fo <= 16'h0000;
    repeat (3) @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    fo <= 16'h9C40;
    repeat (4) @(posedge ref_clk_in);
    #1 chk("frozen", ind.frequency_threshold, 1'b0);
    chk("frozen terminal", term[1], 1'b0);
    @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("thawed", ind.frequency_threshold, 1'b1);
    chk("thawed terminal", term[1], 1'b1);
    $display("freeze done");
    stop_test();
  end
endmodule : drs_status_out_tb
